// *** hw/dma_request_and_global_config.sv ***
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "dma_req_defines.svh"

module dma_request_and_global_config
    import dma_req_pkg::*;
#(
    parameter int NUM_LINES = 16,
    parameter int NUM_CHANS = 2,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic I_CLOCK,
    input wire logic I_SYS_RST,
    // AXI4-Lite register slave.
    input wire logic [31:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [31:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    // Peripheral request lines.
    input wire logic [15:0] I_BURST_REQ_LINES,
    input wire logic [15:0] I_SINGLE_REQ_LINES,
    input wire logic [15:0] I_LAST_BURST_REQ_LINES,
    input wire logic [15:0] I_LAST_SINGLE_REQ_LINES,
    // Completion pulses for the card source's last transactions.
    input wire logic I_CARD_LAST_BURST_DONE,
    input wire logic I_CARD_LAST_SINGLE_DONE,
    // Linked-list item words fetched by the bus master, bit 32 = channel.
    input wire logic [32:0] I_LLI_DATA,
    input wire logic I_LLI_VALID,
    output logic O_LLI_READY,
    // Requests seen by the channel logic and global state.
    output logic [15:0] O_BURST_REQ,
    output logic [15:0] O_SINGLE_REQ,
    output logic [15:0] O_LAST_BURST_REQ,
    output logic [15:0] O_LAST_SINGLE_REQ,
    output logic O_CONTROLLER_ENABLE,
    output logic O_BIG_ENDIAN,
    output logic [1:0] O_CHAN_ENABLE
);

    // The port widths are fixed, so other geometries are refused.
    initial begin
        if (NUM_LINES != 16 || NUM_CHANS != 2 || FIFO_DEPTH < 2) begin
            $error("dma_request_and_global_config: unsupported geometry");
        end
    end

    logic [15:0] sync_ctrl_reg;
    logic [1:0] cfg_reg;
    logic card_lb_flag_reg, card_ls_flag_reg;
    logic [31:0] chan_src_reg [2], chan_dest_reg [2], chan_next_reg [2];
    logic [31:0] chan_ctrl_reg [2], chan_cfg_reg [2];
    logic [63:0] sync_stage1_reg, sync_stage2_reg;
    logic [63:0] raw_lines, eff_lines, bypass;
    logic [15:0] last_burst_pending, last_single_pending;
    logic enabled;
    // Write channel capture.
    logic aw_held_reg, w_held_reg;
    logic [31:0] awaddr_reg, wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic wr_fire, wr_hit;
    logic [31:0] wmask;
    // Read channel.
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic rd_fire, rd_hit;
    logic [31:0] rd_value;
    // Scatter/gather loader.
    load_state_t load_state_reg;
    logic [32:0] lli_word;
    logic lli_valid, lli_take;

    assign enabled = cfg_reg[`CFG_ENABLE_BIT];
    assign O_CONTROLLER_ENABLE = enabled;
    assign O_BIG_ENDIAN = cfg_reg[`CFG_ENDIAN_BIT];
    // Four groups share one sync bit per line index.
    assign raw_lines = {I_LAST_SINGLE_REQ_LINES, I_LAST_BURST_REQ_LINES,
                        I_SINGLE_REQ_LINES, I_BURST_REQ_LINES};
    assign bypass = {4{sync_ctrl_reg}};

    // Two-flop synchronisers; stage one feeds stage two and nothing else.
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            sync_stage1_reg <= 64'h0;
            sync_stage2_reg <= 64'h0;
        end else begin
            sync_stage1_reg <= raw_lines;
            sync_stage2_reg <= sync_stage1_reg;
        end
    end

    // A high sync bit takes the raw line and saves two cycles of latency.
    assign eff_lines = (bypass & raw_lines) | (~bypass & sync_stage2_reg);

    // Pending requests merge lines with the card software flags.
    assign last_burst_pending = eff_lines[47:32]
        | (16'(card_lb_flag_reg) << `CARD_SRC_BIT);
    assign last_single_pending = eff_lines[63:48]
        | (16'(card_ls_flag_reg) << `CARD_SRC_BIT);

    // Requests reach the channels only while the controller is enabled.
    assign O_BURST_REQ = enabled ? eff_lines[15:0] : 16'h0000;
    assign O_SINGLE_REQ = enabled ? eff_lines[31:16] : 16'h0000;
    assign O_LAST_BURST_REQ = enabled ? last_burst_pending : 16'h0000;
    assign O_LAST_SINGLE_REQ = enabled ? last_single_pending : 16'h0000;

    // Each channel runs when its own enable and the global enable are set.
    assign O_CHAN_ENABLE = {2{enabled}}
        & {chan_cfg_reg[1][`CHAN_CFG_ENABLE_BIT],
        chan_cfg_reg[0][`CHAN_CFG_ENABLE_BIT]};

    // Address and data are taken in either order, one write at a time.
    assign O_AWREADY = !aw_held_reg && !bvalid_reg;
    assign O_WREADY = !w_held_reg && !bvalid_reg;
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                    {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 32'h0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end else begin
            if (I_AWVALID && O_AWREADY) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= I_AWADDR;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (I_WVALID && O_WREADY) begin
                w_held_reg <= 1'b1;
                wdata_reg <= I_WDATA;
                wstrb_reg <= I_WSTRB;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Decode of a mapped, word-aligned write address.
    assign wr_hit = chan_addr_ok(awaddr_reg)
        || awaddr_reg inside {`OFS_SW_LAST_BURST_REQUEST,
            `OFS_SW_LAST_SINGLE_REQUEST, `OFS_CONTROLLER_CONFIG,
            `OFS_REQUEST_SYNC_CONTROL};

    // Write response; unmapped addresses answer SLVERR.
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (I_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end
    assign O_BVALID = bvalid_reg;
    assign O_BRESP = bresp_reg;

    // Global configuration registers, byte lanes honoured.
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            cfg_reg <= `RST_CONTROLLER_CONFIG;
            sync_ctrl_reg <= `RST_REQUEST_SYNC_CONTROL;
        end else if (wr_fire) begin
            if (awaddr_reg == `OFS_CONTROLLER_CONFIG && wstrb_reg[0]) begin
                cfg_reg <= wdata_reg[1:0];
            end
            if (awaddr_reg == `OFS_REQUEST_SYNC_CONTROL) begin
                sync_ctrl_reg <= (wdata_reg[15:0] & wmask[15:0])
                    | (sync_ctrl_reg & ~wmask[15:0]);
            end
        end
    end

    // Software request flags: a one sets, a zero is ignored, and the
    // completion pulse clears. A set in the clearing cycle wins, so a
    // fresh request is never lost.
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            card_lb_flag_reg <= 1'b0;
            card_ls_flag_reg <= 1'b0;
        end else begin
            if (wr_fire && awaddr_reg == `OFS_SW_LAST_BURST_REQUEST
                    && wstrb_reg[0] && wdata_reg[`CARD_SRC_BIT]) begin
                card_lb_flag_reg <= 1'b1;
            end else if (I_CARD_LAST_BURST_DONE) begin
                card_lb_flag_reg <= 1'b0;
            end
            if (wr_fire && awaddr_reg == `OFS_SW_LAST_SINGLE_REQUEST
                    && wstrb_reg[0] && wdata_reg[`CARD_SRC_BIT]) begin
                card_ls_flag_reg <= 1'b1;
            end else if (I_CARD_LAST_SINGLE_DONE) begin
                card_ls_flag_reg <= 1'b0;
            end
        end
    end

    // Linked-list words queue here; the loader stalls while disabled,
    // so the queue fills and the master is held off.
    req_fifo #(.WIDTH(33), .DEPTH(FIFO_DEPTH)) u_lli_fifo (
        .i_clk(I_CLOCK),
        .i_rst(I_SYS_RST),
        .i_in_valid(I_LLI_VALID),
        .o_in_ready(O_LLI_READY),
        .i_in_data(I_LLI_DATA),
        .o_out_valid(lli_valid),
        .i_out_ready(lli_take),
        .o_out_data(lli_word),
        .o_full(),
        .o_empty()
    );
    assign lli_take = enabled;

    // Word order of one item: source, destination, next item, control.
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            load_state_reg <= LOAD_SRC;
        end else if (lli_valid && lli_take) begin
            case (load_state_reg)
                LOAD_SRC: load_state_reg <= LOAD_DEST;
                LOAD_DEST: load_state_reg <= LOAD_NEXT;
                LOAD_NEXT: load_state_reg <= LOAD_CTRL;
                LOAD_CTRL: load_state_reg <= LOAD_SRC;
                default: load_state_reg <= LOAD_SRC;
            endcase
        end
    end

    // Channel registers; a reload word beats a bus write in the same cycle.
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            for (int c = 0; c < 2; c++) begin
                chan_src_reg[c] <= `RST_CHAN_WORD;
                chan_dest_reg[c] <= `RST_CHAN_WORD;
                chan_next_reg[c] <= `RST_CHAN_WORD;
                chan_ctrl_reg[c] <= `RST_CHAN_WORD;
                chan_cfg_reg[c] <= `RST_CHAN_WORD;
            end
        end else begin
            if (wr_fire && chan_addr_ok(awaddr_reg)) begin
                case (awaddr_reg[4:2])
                    `CHAN_WORD_SRC: chan_src_reg[awaddr_reg[5]] <=
                        merge(chan_src_reg[awaddr_reg[5]]);
                    `CHAN_WORD_DEST: chan_dest_reg[awaddr_reg[5]] <=
                        merge(chan_dest_reg[awaddr_reg[5]]);
                    `CHAN_WORD_NEXT: chan_next_reg[awaddr_reg[5]] <=
                        merge(chan_next_reg[awaddr_reg[5]]) & 32'hfffffffc;
                    `CHAN_WORD_CTRL: chan_ctrl_reg[awaddr_reg[5]] <=
                        merge(chan_ctrl_reg[awaddr_reg[5]]);
                    `CHAN_WORD_CFG: chan_cfg_reg[awaddr_reg[5]] <=
                        merge(chan_cfg_reg[awaddr_reg[5]]);
                    default: ;
                endcase
            end
            if (lli_valid && lli_take) begin
                case (load_state_reg)
                    LOAD_SRC: chan_src_reg[lli_word[32]] <=
                        lli_word[31:0];
                    LOAD_DEST: chan_dest_reg[lli_word[32]] <=
                        lli_word[31:0];
                    LOAD_NEXT: chan_next_reg[lli_word[32]] <=
                        lli_word[31:0] & 32'hfffffffc;
                    LOAD_CTRL: chan_ctrl_reg[lli_word[32]] <=
                        lli_word[31:0];
                    default: ;
                endcase
            end
        end
    end

    // Read side: one read at a time, data held until taken.
    assign O_ARREADY = !rvalid_reg;
    assign rd_fire = I_ARVALID && O_ARREADY;

    // Read mux; reserved bits read as zero.
    always_comb begin
        rd_value = 32'h0;
        rd_hit = 1'b1;
        case (I_ARADDR)
            `OFS_SW_LAST_BURST_REQUEST:
                rd_value = {16'h0, last_burst_pending};
            `OFS_SW_LAST_SINGLE_REQUEST:
                rd_value = {16'h0, last_single_pending};
            `OFS_CONTROLLER_CONFIG: rd_value = {30'h0, cfg_reg};
            `OFS_REQUEST_SYNC_CONTROL: rd_value = {16'h0, sync_ctrl_reg};
            default: begin
                rd_hit = chan_addr_ok(I_ARADDR);
                case (I_ARADDR[4:2])
                    `CHAN_WORD_SRC: rd_value = chan_src_reg[I_ARADDR[5]];
                    `CHAN_WORD_DEST: rd_value = chan_dest_reg[I_ARADDR[5]];
                    `CHAN_WORD_NEXT: rd_value = chan_next_reg[I_ARADDR[5]];
                    `CHAN_WORD_CTRL: rd_value = chan_ctrl_reg[I_ARADDR[5]];
                    `CHAN_WORD_CFG: rd_value = chan_cfg_reg[I_ARADDR[5]];
                    default: rd_value = 32'h0;
                endcase
                if (!rd_hit) begin
                    rd_value = 32'h0;
                end
            end
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_value;
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (I_RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end
    assign O_RVALID = rvalid_reg;
    assign O_RDATA = rdata_reg;
    assign O_RRESP = rresp_reg;

    // True for a word-aligned address of one of the ten channel registers.
    function automatic logic chan_addr_ok(input logic [31:0] a);
        logic [31:0] rel;
        rel = a - `OFS_CHAN_BASE;
        chan_addr_ok = (rel < (`OFS_CHAN_STRIDE << 1))
            && (rel[1:0] == 2'b00) && (rel[4:2] <= `CHAN_WORD_CFG);
    endfunction

    // Byte-lane merge of the captured write data into an old value.
    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (wdata_reg & wmask) | (old & ~wmask);
    endfunction

endmodule

// *** hw/req_fifo.sv ***
`timescale 1ns/10ps

// Synchronous FIFO whose head word is held in an output register.
module req_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic o_full,
    output logic o_empty
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Refuse depths that the pointer arithmetic cannot wrap correctly.
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("req_fifo: DEPTH must be a power of two >= 2");
        end
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic out_valid_reg;
    logic push;
    logic pop;

    // The output register refills whenever it is empty or being drained.
    assign push = i_in_valid && o_in_ready;
    assign pop = (count_reg != '0) && (!out_valid_reg || i_out_ready);
    assign o_in_ready = (count_reg != DEPTH[AW:0]);
    assign o_full = !o_in_ready;
    assign o_empty = !out_valid_reg;
    assign o_out_valid = out_valid_reg;

    // Storage array.
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end

    // Pointers and fill count.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // Registered read data.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            out_valid_reg <= 1'b0;
            o_out_data <= '0;
        end else if (pop) begin
            out_valid_reg <= 1'b1;
            o_out_data <= mem_reg[rd_ptr_reg];
        end else if (i_out_ready) begin
            out_valid_reg <= 1'b0;
        end
    end

endmodule

// *** inc/dma_req_defines.svh ***
`ifndef DMA_REQ_DEFINES_SVH
`define DMA_REQ_DEFINES_SVH

// Byte addresses of the global registers.
`define OFS_SW_LAST_BURST_REQUEST 32'hffe04028
`define OFS_SW_LAST_SINGLE_REQUEST 32'hffe0402c
`define OFS_CONTROLLER_CONFIG 32'hffe04030
`define OFS_REQUEST_SYNC_CONTROL 32'hffe04034

// Channel register window: base of channel 0, channel stride in bytes.
`define OFS_CHAN_BASE 32'hffe04100
`define OFS_CHAN_STRIDE 32'h00000020

// Word index of each register inside one channel's window.
`define CHAN_WORD_SRC 3'h0
`define CHAN_WORD_DEST 3'h1
`define CHAN_WORD_NEXT 3'h2
`define CHAN_WORD_CTRL 3'h3
`define CHAN_WORD_CFG 3'h4

// Field positions.
`define CARD_SRC_BIT 4
`define CFG_ENABLE_BIT 0
`define CFG_ENDIAN_BIT 1
`define CHAN_CFG_ENABLE_BIT 0

// Reset values.
`define RST_CONTROLLER_CONFIG 2'h0
`define RST_REQUEST_SYNC_CONTROL 16'h0000
`define RST_CHAN_WORD 32'h00000000

`endif

// *** inc/dma_req_pkg.sv ***
package dma_req_pkg;

    // AXI response codes.
    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;

    // Which channel register the next linked-list word reloads.
    typedef enum logic [1:0] {
        LOAD_SRC = 2'b00,
        LOAD_DEST = 2'b01,
        LOAD_NEXT = 2'b10,
        LOAD_CTRL = 2'b11
    } load_state_t;

endpackage

// *** verif/dma_cfg_properties.sv ***
`timescale 1ns/10ps

// Relations between the block's pins, checked on every clock outside reset.
module dma_cfg_properties (
    input wire logic I_CLOCK,
    input wire logic I_SYS_RST,
    input wire logic I_ARVALID,
    input wire logic O_ARREADY,
    input wire logic O_AWREADY,
    input wire logic O_WREADY,
    input wire logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic O_RVALID,
    input wire logic I_RREADY,
    input wire logic [15:0] I_BURST_REQ_LINES,
    input wire logic [15:0] O_BURST_REQ,
    input wire logic [15:0] O_SINGLE_REQ,
    input wire logic O_CONTROLLER_ENABLE,
    input wire logic [1:0] O_CHAN_ENABLE,
    input wire logic I_LLI_VALID,
    input wire logic O_LLI_READY
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_SYS_RST);

    // A line held for three samples has settled through either path.
    a_steady_lines:
    assert property (O_CONTROLLER_ENABLE && $past(O_CONTROLLER_ENABLE, 2)
        && $stable(I_BURST_REQ_LINES)
        && I_BURST_REQ_LINES == $past(I_BURST_REQ_LINES, 2)
        |-> O_BURST_REQ == I_BURST_REQ_LINES)
        else $error("request line not passed on");
    a_off_no_req:
    assert property (!O_CONTROLLER_ENABLE
        |-> O_BURST_REQ == 16'h0000 && O_SINGLE_REQ == 16'h0000)
        else $error("request seen while disabled");
    a_chan_gated:
    assert property (O_CHAN_ENABLE != 2'h0 |-> O_CONTROLLER_ENABLE)
        else $error("channel enabled while controller off");
    a_rd_answer:
    assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
        else $error("read not answered");
    a_rd_once:
    assert property (O_RVALID && I_RREADY |=> !O_RVALID)
        else $error("read answered twice");
    a_no_ar_busy:
    assert property (O_RVALID |-> !O_ARREADY)
        else $error("read taken while busy");
    a_wr_once:
    assert property (O_BVALID && I_BREADY |=> !O_BVALID)
        else $error("write answered twice");
    a_no_aw_busy:
    assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
        else $error("write taken while busy");

    c_write: cover property (O_BVALID && I_BREADY);
    c_read: cover property (O_RVALID && I_RREADY);
    c_lli: cover property (I_LLI_VALID && O_LLI_READY);
endmodule

bind dma_request_and_global_config dma_cfg_properties i_props (
    .I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_ARVALID(I_ARVALID),
    .O_ARREADY(O_ARREADY), .O_AWREADY(O_AWREADY), .O_WREADY(O_WREADY),
    .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .O_RVALID(O_RVALID),
    .I_RREADY(I_RREADY), .I_BURST_REQ_LINES(I_BURST_REQ_LINES),
    .O_BURST_REQ(O_BURST_REQ), .O_SINGLE_REQ(O_SINGLE_REQ),
    .O_CONTROLLER_ENABLE(O_CONTROLLER_ENABLE), .O_CHAN_ENABLE(O_CHAN_ENABLE),
    .I_LLI_VALID(I_LLI_VALID), .O_LLI_READY(O_LLI_READY));

// *** verif/dma_request_and_global_config_test.sv ***
`timescale 1ns/10ps
`include "dma_req_defines.svh"

// Self-checking bench for the request and global config slice.
module dma_request_and_global_config_test import dma_req_pkg::*;;
    logic clk = 1'b0, rst = 1'b1;
    logic [31:0] aw = 32'h0, wd = 32'h0, ar = 32'h0, rdat, got, e;
    logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0, dlb = 0, dls = 0;
    logic [15:0] bl = 0, sl = 0, lbl = 0, lsl = 0, ob, os, olb, ols;
    logic awr, wrr, bv, arr, rv, lv, lr, en, be;
    logic [1:0] bresp, rresp, ce, rsp;
    logic [32:0] ld;
    int fails = 0, checked = 0, cyc = 0, cnt;

    initial forever #2.5 clk = ~clk;

    dma_request_and_global_config i_dut (
        .I_CLOCK(clk), .I_SYS_RST(rst), .I_AWADDR(aw), .I_AWVALID(awv),
        .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hf), .I_WVALID(wv),
        .O_WREADY(wrr), .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(br),
        .I_ARADDR(ar), .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdat),
        .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rr),
        .I_BURST_REQ_LINES(bl), .I_SINGLE_REQ_LINES(sl),
        .I_LAST_BURST_REQ_LINES(lbl), .I_LAST_SINGLE_REQ_LINES(lsl),
        .I_CARD_LAST_BURST_DONE(dlb), .I_CARD_LAST_SINGLE_DONE(dls),
        .I_LLI_DATA(ld), .I_LLI_VALID(lv), .O_LLI_READY(lr),
        .O_BURST_REQ(ob), .O_SINGLE_REQ(os), .O_LAST_BURST_REQ(olb),
        .O_LAST_SINGLE_REQ(ols), .O_CONTROLLER_ENABLE(en),
        .O_BIG_ENDIAN(be), .O_CHAN_ENABLE(ce));
    lli_source i_src (.i_clk(clk), .i_rst(rst), .i_ready(lr),
        .o_valid(lv), .o_data(ld), .o_count(cnt));

    task report_and_stop;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // A hang counts as a mismatch and ends the run.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    task chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            fails++;
            $display("unexpected at %0t got %h exp %h", $time, g, x);
        end
    endtask

    // Address and data are offered together; each drops when taken.
    task wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        aw <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 0;
            if (wv && wrr) wv <= 0;
        end while (!bv);
        rsp = bresp;
        br <= 0;
    endtask

    task rd(input logic [31:0] a);
        @(posedge clk);
        ar <= a; arv <= 1; rr <= 1;
        do begin
            @(posedge clk);
            if (arv && arr) arv <= 0;
        end while (!rv);
        got = rdat;
        rsp = rresp;
        rr <= 0;
    endtask

    task t_reset_and_cfg;
        rd(`OFS_CONTROLLER_CONFIG); chk(got, 32'h0);
        rd(`OFS_REQUEST_SYNC_CONTROL); chk(got, 32'h0);
        wr(`OFS_CONTROLLER_CONFIG, 32'h3); chk(32'(be), 32'h1);
        chk(32'(rsp), 32'(RESP_OKAY));
        wr(`OFS_CONTROLLER_CONFIG, 32'h1); chk(32'(be), 32'h0);
        chk(32'(en), 32'h1);
        $display("test reset and config done");
    endtask

    // Set the card flag, try to clear it by a zero, then end it by done.
    task t_soft(input logic [31:0] a, input logic single);
        wr(a, 32'h10); rd(a); chk(got, 32'h10);
        chk(32'(single ? ols[4] : olb[4]), 32'h1);
        wr(a, 32'h0); rd(a); chk(got, 32'h10);
        @(posedge clk); dlb <= !single; dls <= single;
        @(posedge clk); dlb <= 0; dls <= 0;
        rd(a); chk(got, 32'h0);
        $display("test software flag done");
    endtask

    task setl(input logic [15:0] v);
        bl <= v; sl <= v; lbl <= v; lsl <= v;
    endtask

    // Index 3 is synchronised first, then bypassed beside index 5.
    task t_sync;
        @(posedge clk); setl(16'h0008);
        @(posedge clk); #1 chk(32'(ob), 32'h0);
        @(posedge clk); #1 chk(32'(ols), 32'h8);
        wr(`OFS_REQUEST_SYNC_CONTROL, 32'h8);
        // Line index 4 stays idle, so the card source never mixes kinds.
        @(posedge clk); setl(16'h0028);
        #1 chk(32'(os), 32'h8); chk(32'(olb), 32'h8);
        @(posedge clk); setl(16'h0000);
        wr(`OFS_REQUEST_SYNC_CONTROL, 32'h0);
        rd(32'hffe04200); chk(32'(rsp), 32'(RESP_SLVERR));
        wr(32'hffe04200, 32'h1); chk(32'(rsp), 32'(RESP_SLVERR));
        $display("test sync done");
    endtask

    // Words stall while disabled, then three items reload both channels.
    task t_lli;
        wr(`OFS_CONTROLLER_CONFIG, 32'h0);
        setl(16'h0001);
        for (int i = 0; i < 12; i++)
            i_src.push({i / 4 == 1, 32'ha0000000 + 32'(i) * 32'h11});
        repeat (40) @(posedge clk);
        chk(32'(cnt), 32'h9); chk(32'(lr), 32'h0);
        chk(32'(ob), 32'h0); chk(32'(olb), 32'h0);
        setl(16'h0000);
        wr(`OFS_CONTROLLER_CONFIG, 32'h1);
        repeat (40) @(posedge clk);
        chk(32'(cnt), 32'hc);
        for (int c = 0; c < 2; c++)
            for (int w = 0; w < 4; w++) begin
                rd(`OFS_CHAN_BASE + 32'(c * 32 + w * 4));
                e = 32'ha0000000 + 32'((c ? 4 : 8) + w) * 32'h11;
                if (w == 2) e[1:0] = 2'h0;
                chk(got, e);
            end
        wr(`OFS_CHAN_BASE + 32'h30, 32'h1); chk(32'(ce), 32'h2);
        $display("test linked list done");
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        t_reset_and_cfg();
        t_soft(`OFS_SW_LAST_BURST_REQUEST, 1'b0);
        t_soft(`OFS_SW_LAST_SINGLE_REQUEST, 1'b1);
        t_sync();
        t_lli();
        report_and_stop();
    end
endmodule

// *** verif/lli_source.sv ***
`timescale 1ns/10ps

// Bus master side feeding linked-list words, each held until taken.
module lli_source (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ready,
    output logic o_valid = 1'b0,
    output logic [32:0] o_data = 33'h000000000,
    output int o_count = 0
);
    logic [32:0] q[$];

    // The bench queues whole items in the order src, dest, next, control.
    task push(input logic [32:0] w);
        q.push_back(w);
    endtask

    // Idle data toggles, so a stale word never passes for a fresh one.
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_valid <= 1'b0;
            o_count <= 0;
        end else if (!o_valid || i_ready) begin
            if (o_valid) o_count <= o_count + 1;
            if (q.size() > 0) begin
                o_valid <= 1'b1;
                o_data <= q.pop_front();
            end else begin
                o_valid <= 1'b0;
                o_data <= ~o_data;
            end
        end
    end
endmodule
